// File: hdl/adc_serial_pkg.sv
package adc_serial_pkg;

   localparam int RES_W          = 8;
   localparam int ADDR_BITS      = 2;
   localparam int FIFO_DEPTH_DEF = 16;
   localparam int IDX_W          = 3;

   localparam logic [IDX_W-1:0] IDX_MSB          = 3'h7;
   localparam logic [IDX_W-1:0] IDX_LSB          = 3'h0;
   localparam logic [IDX_W-1:0] IDX_REPEAT_FIRST = 3'h1;
   localparam logic [1:0]       ADDR_CNT_RST     = 2'h0;
   localparam logic [1:0]       ADDR_LAST        = 2'h1;
   localparam logic [RES_W-1:0] RESULT_RST       = 8'h00;

   typedef struct packed {
      logic single_or_differential_select;
      logic odd_select;
   } mux_cfg_s;

   localparam mux_cfg_s MUX_CFG_RST = 2'h0;

   typedef struct packed {
      mux_cfg_s         cfg;
      logic [RES_W-1:0] code;
   } conv_result_s;

   typedef enum logic [2:0] {
      ST_WAIT,
      ST_ADDR,
      ST_SETTLE,
      ST_MSB,
      ST_LSB,
      ST_DONE
   } conv_state_e;

endpackage

// File: hdl/input_mux.sv
`timescale 1ns/10ps
module input_mux
   import adc_serial_pkg::*;
#(
   parameter bit TWIN_CHANNEL = 1'b1,
   parameter int W            = RES_W
) (
   input  wire logic [W-1:0] analog_input_zero,
   input  wire logic [W-1:0] analog_input_one,
   input  wire mux_cfg_s     cfg,
   output logic [W-1:0]      diff
);

   logic [W-1:0] pos;
   logic [W-1:0] neg;

   always_comb begin
      pos = analog_input_zero;
      neg = analog_input_one;
      if (TWIN_CHANNEL) begin
         case ({cfg.single_or_differential_select, cfg.odd_select})
            2'b00: begin
               pos = analog_input_zero;
               neg = analog_input_one;
            end
            2'b01: begin
               pos = analog_input_one;
               neg = analog_input_zero;
            end
            2'b10: begin
               pos = analog_input_zero;
               neg = '0;
            end
            default: begin
               pos = analog_input_one;
               neg = '0;
            end
         endcase
      end
      if (pos < neg) begin
         diff = '0;
      end else begin
         diff = pos - neg;
      end
   end

endmodule

// File: hdl/result_fifo.sv
`timescale 1ns/10ps
module result_fifo #(
   parameter int W     = 10,
   parameter int DEPTH = 16
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);

   localparam int PW = $clog2(DEPTH);

   logic [W-1:0]  mem_q [DEPTH];
   logic [PW-1:0] wr_q;
   logic [PW-1:0] rd_q;
   logic [PW:0]   cnt_q;
   logic          push;
   logic          pop;

   assign in_ready  = cnt_q != (PW+1)'(DEPTH);
   assign out_valid = cnt_q != '0;
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   // storage is flops, so the head word is already registered
   assign out_data  = mem_q[rd_q];

   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         if (push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= rd_q + 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cnt_q <= '0;
      end else begin
         case ({push, pop})
            2'b10:   cnt_q <= cnt_q + 1'b1;
            2'b01:   cnt_q <= cnt_q - 1'b1;
            default: cnt_q <= cnt_q;
         endcase
      end
   end

endmodule

// File: hdl/adc_serial_ctrl.sv
`timescale 1ns/10ps
module adc_serial_ctrl
   import adc_serial_pkg::*;
#(
   parameter bit TWIN_CHANNEL = 1'b1,
   parameter int FIFO_DEPTH   = FIFO_DEPTH_DEF
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             cs_n,
   input  wire logic             serial_command_in,
   output logic                  serial_data_out,
   output logic                  serial_data_out_oe,
   input  wire logic [RES_W-1:0] analog_input_zero,
   input  wire logic [RES_W-1:0] analog_input_one,
   output mux_cfg_s              mux_cfg,
   output logic                  busy,
   output logic                  result_valid,
   input  wire logic             result_ready,
   output conv_result_s          result_data
);

   conv_state_e      state_q;
   conv_state_e      state_d;
   logic [1:0]       addr_cnt_q;
   mux_cfg_s         addr_shift_q;
   mux_cfg_s         cfg_q;
   logic [IDX_W-1:0] idx_q;
   logic [RES_W-1:0] res_q;
   logic [RES_W-1:0] held_q;
   logic             dout_q;
   logic             oe_q;
   logic             busy_q;
   logic [RES_W-1:0] diff_now;
   logic [RES_W-1:0] diff_use;
   logic [RES_W-1:0] part_use;
   logic             dec_bit;
   logic             start_seen;
   logic             addr_done;
   logic             fifo_in_valid;
   logic             fifo_in_ready;
   conv_result_s     fifo_in_data;

   // one-hot weight of a bit position, shared by the decision and the kept code
   function automatic logic [RES_W-1:0] bit_weight(input logic [IDX_W-1:0] idx);
      return RES_W'(1) << idx;
   endfunction

   // one comparator step: keep the trial bit if the span passed in (live at settle, held after) reaches it
   function automatic logic sar_bit(
      input logic [RES_W-1:0] span,
      input logic [RES_W-1:0] partial,
      input logic [IDX_W-1:0] idx
   );
      logic [RES_W-1:0] trial;
      trial = partial | bit_weight(idx);
      return span >= trial;
   endfunction

   input_mux #(
      .TWIN_CHANNEL (TWIN_CHANNEL),
      .W            (RES_W)
   ) u_mux (
      .analog_input_zero (analog_input_zero),
      .analog_input_one  (analog_input_one),
      .cfg               (cfg_q),
      .diff              (diff_now)
   );

   // start is held off while the result queue is full, so no code is lost
   // first high is start
   assign start_seen = (state_q == ST_WAIT) && serial_command_in && fifo_in_ready;
   assign addr_done  = (state_q == ST_ADDR) && (addr_cnt_q == ADDR_LAST);

   // the first decision compares the live mux output, later ones the held span
   assign diff_use = (state_q == ST_SETTLE) ? diff_now : held_q;
   assign part_use = (state_q == ST_SETTLE) ? RESULT_RST : res_q;
   assign dec_bit  = sar_bit(diff_use, part_use, idx_q);

   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_WAIT: begin
            if (start_seen) begin
               state_d = TWIN_CHANNEL ? ST_ADDR : ST_SETTLE;
            end
         end
         ST_ADDR: begin
            if (addr_done) begin
               state_d = ST_SETTLE;
            end
         end
         ST_SETTLE: begin
            state_d = ST_MSB;
         end
         ST_MSB: begin
            if (idx_q == IDX_LSB) begin
               state_d = TWIN_CHANNEL ? ST_LSB : ST_DONE;
            end
         end
         ST_LSB: begin
            if (idx_q == IDX_MSB) begin
               state_d = ST_DONE;
            end
         end
         ST_DONE: begin
            state_d = ST_DONE;
         end
         default: begin
            state_d = ST_WAIT;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n || cs_n) begin
         state_q <= ST_WAIT;
      end else begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n || cs_n) begin
         addr_shift_q <= MUX_CFG_RST;
      end else if (state_q == ST_ADDR) begin
         addr_shift_q <= {addr_shift_q.odd_select, serial_command_in};
      end
   end

   // counts word bits so the config lands in place right after the odd bit
   always_ff @(posedge clk) begin
      if (!rst_n || cs_n) begin
         addr_cnt_q <= ADDR_CNT_RST;
      end else if (state_q == ST_ADDR) begin
         addr_cnt_q <= addr_cnt_q + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n || cs_n) begin
         cfg_q <= MUX_CFG_RST;
      end else if (addr_done) begin
         cfg_q <= {addr_shift_q.odd_select, serial_command_in};
      end
   end

   // bit pointer walks down for the first stream, up for the repeat
   always_ff @(posedge clk) begin
      if (!rst_n || cs_n) begin
         idx_q <= IDX_MSB;
      end else begin
         case (state_q)
            ST_SETTLE: begin
               idx_q <= idx_q - 1'b1;
            end
            ST_MSB: begin
               if (idx_q == IDX_LSB) begin
                  idx_q <= IDX_REPEAT_FIRST;
               end else begin
                  idx_q <= idx_q - 1'b1;
               end
            end
            ST_LSB: begin
               // wraps to zero on the last repeat bit, harmless as done follows
               idx_q <= idx_q + 1'b1;
            end
            default: begin
               idx_q <= IDX_MSB;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n || cs_n) begin
         res_q <= RESULT_RST;
      end else if (state_q == ST_SETTLE) begin
         res_q <= dec_bit ? bit_weight(idx_q) : RESULT_RST;
      end else if (state_q == ST_MSB && dec_bit) begin
         res_q <= res_q | bit_weight(idx_q);
      end
   end

   // span frozen at the settling edge so later input moves cannot upset the search
   always_ff @(posedge clk) begin
      if (!rst_n || cs_n) begin
         held_q <= RESULT_RST;
      end else if (state_q == ST_SETTLE) begin
         held_q <= diff_now;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n || cs_n) begin
         oe_q <= 1'b0;
      end else begin
         case (state_q)
            ST_WAIT: begin
               oe_q <= start_seen && !TWIN_CHANNEL;
            end
            ST_ADDR: begin
               oe_q <= addr_done;
            end
            ST_SETTLE, ST_MSB, ST_LSB: begin
               oe_q <= 1'b1;
            end
            default: begin
               oe_q <= 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n || cs_n) begin
         dout_q <= 1'b0;
      end else begin
         case (state_q)
            ST_SETTLE, ST_MSB: begin
               dout_q <= dec_bit;
            end
            ST_LSB: begin
               dout_q <= res_q[idx_q];
            end
            default: begin
               // low while floating or settling keeps a shared wire quiet
               dout_q <= 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n || cs_n) begin
         busy_q <= 1'b0;
      end else begin
         busy_q <= (state_d != ST_WAIT) && (state_d != ST_DONE);
      end
   end

   // full code queued after eighth
   // a deselect on the last decision edge cuts the frame, so nothing is queued
   assign fifo_in_valid = (state_q == ST_MSB) && (idx_q == IDX_LSB) && !cs_n;
   assign fifo_in_data  = '{cfg: cfg_q, code: res_q | RES_W'(dec_bit)};

   result_fifo #(
      .W     ($bits(conv_result_s)),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .rst_n     (rst_n),
      .in_valid  (fifo_in_valid),
      .in_ready  (fifo_in_ready),
      .in_data   (fifo_in_data),
      .out_valid (result_valid),
      .out_ready (result_ready),
      .out_data  (result_data)
   );

   assign serial_data_out    = dout_q;
   assign serial_data_out_oe = oe_q;
   assign mux_cfg            = cfg_q;
   assign busy               = busy_q;

endmodule

// File: verif/adc_serial_checker.sv
`timescale 1ns/10ps
module adc_serial_checker
   import adc_serial_pkg::*;
(
   input wire logic         clk,
   input wire logic         rst_n,
   input wire logic         cs_n,
   input wire logic         serial_command_in,
   input wire logic         serial_data_out,
   input wire logic         serial_data_out_oe,
   input wire logic         busy,
   input wire mux_cfg_s     mux_cfg,
   input wire logic         result_valid,
   input wire logic         result_ready,
   input wire conv_result_s result_data
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_word;
      $rose(busy) ##0 (!cs_n) [*2];
   endsequence
   // natural end only: an abort drops the enable one edge after deselect
   sequence s_end;
      $fell(serial_data_out_oe) && !$past(cs_n);
   endsequence
   a_deselect_floats: assert property (cs_n |=> !serial_data_out_oe && !busy)
      else $error("output still driven after deselect");
   a_float_zero: assert property (!serial_data_out_oe |-> !serial_data_out)
      else $error("data not low while floating");
   a_settle_low: assert property ($rose(serial_data_out_oe) |-> !serial_data_out && $past(busy))
      else $error("settling bit not low");
   a_start_high: assert property ($rose(busy) |-> $past(serial_command_in) && !$past(cs_n))
      else $error("start taken without high bit");
   a_no_start: assert property (!busy && !serial_data_out_oe && (cs_n || !serial_command_in) |=> !busy)
      else $error("conversion began without start");
   a_cfg_applied: assert property (s_word |=> mux_cfg == {$past(serial_command_in, 2), $past(serial_command_in)})
      else $error("applied config differs from word");
   a_stream_length: assert property (s_end |-> $past(serial_data_out_oe, 16) && !$past(serial_data_out_oe, 17))
      else $error("output stream length wrong");
   a_repeat_lsb: assert property (s_end |-> $past(serial_data_out, 7) == $past(serial_data_out, 9)
                                  && $past(serial_data_out, 1) == $past(serial_data_out, 15))
      else $error("repeat stream differs");
   a_valid_hold: assert property (result_valid && !result_ready |=> result_valid && $stable(result_data))
      else $error("queued result changed while held");
endmodule

// File: verif/adc_host_model.sv
`timescale 1ns/10ps
module adc_host_model (
   input  wire logic clk,
   output logic      cs_n,
   output logic      cmd,
   input  wire logic dout,
   input  wire logic dout_oe
);
   initial begin
      cs_n = 1'b1;
      cmd  = 1'b0;
   end
   task automatic frame(input logic [1:0] c, input int lead, input int stop, output logic [15:0] bits,
                        output logic [16:0] oes);
      @(negedge clk);
      cs_n = 1'b0;
      cmd  = (lead == 0);
      if (lead > 0) begin
         repeat (lead) @(negedge clk);
         cmd = 1'b1;
      end
      @(negedge clk);
      cmd = c[1];
      @(negedge clk);
      cmd = c[0];
      for (int i = 0; i < 17; i++) begin
         @(negedge clk);
         // released wire toggles so a stale level cannot pass
         cmd = ~cmd;
         if (i == stop) cs_n = 1'b1;
         oes[16-i] = dout_oe;
         if (i < 16) bits[15-i] = dout;
      end
      @(negedge clk);
      cs_n = 1'b1;
      cmd  = 1'b0;
   endtask
endmodule

// File: verif/serial_adc_mux_control_test.sv
`timescale 1ns/10ps
module serial_adc_mux_control_test
   import adc_serial_pkg::*;
;
   logic             clk, rst_n, cs_n, cmd, dout, doe, busy, result_valid, result_ready;
   logic [RES_W-1:0] ain0, ain1;
   mux_cfg_s         mux_cfg;
   conv_result_s     result_data;
   conv_result_s     q[$];
   int               num_errors, n_tests;

   adc_serial_ctrl u_dut (.clk(clk), .rst_n(rst_n), .cs_n(cs_n), .serial_command_in(cmd), .serial_data_out(dout),
      .serial_data_out_oe(doe), .analog_input_zero(ain0), .analog_input_one(ain1), .mux_cfg(mux_cfg),
      .busy(busy), .result_valid(result_valid), .result_ready(result_ready), .result_data(result_data));
   adc_host_model u_host (.clk(clk), .cs_n(cs_n), .cmd(cmd), .dout(dout), .dout_oe(doe));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic check_link(string name, logic [16:0] exp, logic [16:0] got);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s exp %h got %h", name, exp, got);
      end
   endtask

   task automatic check_word(conv_result_s exp, conv_result_s got);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED result exp %h got %h", exp, got);
      end
   endtask

   task automatic print_verdict();
      if (num_errors == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   task automatic run(logic [1:0] c, int stop, logic push);
      logic [15:0] bits, eb;
      logic [16:0] oes, eo;
      int          p, n;
      logic [7:0]  code;
      ain0 = 8'($urandom);
      ain1 = 8'($urandom);
      p    = c[0] ? ain1 : ain0;
      n    = c[1] ? 0 : (c[0] ? ain0 : ain1);
      code = (p < n) ? 8'h00 : 8'(p - n);
      eb   = {1'b0, code, 7'h00};
      for (int j = 0; j < 7; j++) eb[6-j] = code[1+j];
      eo = 17'h1fffe;
      for (int i = stop + 1; i < 17; i++) begin
         eo[16-i] = 1'b0;
         if (i < 16) eb[15-i] = 1'b0;
      end
      // a full queue holds the device in wait, so nothing is driven
      if (!push) begin
         eo = 17'h0;
         eb = 16'h0;
      end
      u_host.frame(c, $urandom_range(2, 0), stop, bits, oes);
      check_link("enable", eo, oes);
      check_link("stream", {1'b0, eb}, {1'b0, bits});
      if (push && stop > 15) q.push_back({c, code});
   endtask

   initial begin
      rst_n        = 1'b0;
      result_ready = 1'b0;
      ain0         = 8'h00;
      ain1         = 8'h00;
      num_errors   = 0;
      n_tests      = 0;
      void'($urandom(32'hd80dfaae));
      repeat (10) @(negedge clk);
      rst_n = 1'b1;
      // deselect seen on the edge that decides the last bit: no word may be queued
      run(2'h1, 7, 1'b1);
      for (int k = 0; k < 16; k++) run(2'(k), 99, 1'b1);
      run(2'h3, 99, 1'b0);
      result_ready = 1'b1;
      while (q.size() > 0) begin
         check_link("valid", 17'h1, {16'h0, result_valid});
         check_word(q.pop_front(), result_data);
         @(negedge clk);
      end
      check_link("empty", 17'h0, {16'h0, result_valid});
      print_verdict();
   end

   initial begin
      #20000;
      num_errors++;
      print_verdict();
   end
endmodule

bind adc_serial_ctrl adc_serial_checker u_chk (.clk(clk), .rst_n(rst_n), .cs_n(cs_n),
   .serial_command_in(serial_command_in), .serial_data_out(serial_data_out),
   .serial_data_out_oe(serial_data_out_oe), .busy(busy), .mux_cfg(mux_cfg), .result_valid(result_valid),
   .result_ready(result_ready), .result_data(result_data));
